// ### hw/fspc_pkg.sv
// Package for the flash sector protection controller.
// Assumes a 16-bit CPU address space with flash mapped at its top.
package fspc_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] REG_CTL_IDX = 8'h29;
  localparam logic [7:0] REG_ADDR_IDX = 8'h80;
  localparam logic [7:0] REG_WDATA_IDX = 8'h81;
  localparam logic [7:0] REG_RDATA_IDX = 8'h82;
  localparam logic [7:0] REG_OPT_IDX = 8'h83;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int CTL_PROG_BIT = 0;
  localparam int CTL_SERASE_BIT = 1;
  localparam int CTL_MERASE_BIT = 2;
  localparam int CTL_BUSY_BIT = 3;
  localparam int CTL_DONE_BIT = 4;
  localparam int CTL_REFUSED_BIT = 5;

  localparam int OPT_RP_BIT = 0;
  localparam int OPT_DETECTOR_BIT = 1;

  localparam int KBYTE = 1024;
  localparam int SMALL_KB = 4;
  localparam int MID_KB = 8;
  localparam logic [16:0] ADDR_SPACE = 17'h10000;
  localparam logic [15:0] SECTOR0_BASE = 16'hF000;
  localparam logic [15:0] SECTOR1_BASE = 16'hE000;
  localparam logic [15:0] SECTOR1_LAST = 16'hEFFF;
  localparam logic [15:0] SECTOR2_LAST = 16'hDFFF;
  localparam logic [15:0] ADDR_LAST = 16'hFFFF;
  localparam logic [1:0] SECT_0 = 2'h0;
  localparam logic [1:0] SECT_1 = 2'h1;
  localparam logic [1:0] SECT_2 = 2'h2;
  localparam logic [1:0] SECT_NONE = 2'h3;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PROG = 2'b01,
    S_ERASE = 2'b10,
    S_UNPROT = 2'b11
  } fspc_state_e;

endpackage : fspc_pkg

// ### hw/fspc_mem.sv
// Byte-wide flash array model with one write and one read port.
// Assumes the controller serialises all writes; read data is registered.
`timescale 1ns/10ps
module fspc_mem #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    o_rdata <= mem[i_raddr];
  end

endmodule : fspc_mem

// ### hw/fspc_ctrl.sv
// Flash access and sector protection controller with Avalon-MM registers.
// Assumes tool pins are asynchronous and the bus master is on I_REF_CLK.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
module fspc_ctrl #(
  parameter int FLASH_KB = 60,
  parameter bit RP_DEFAULT = 1'b0
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic [9:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_TOOL_PRESENT,
  input wire logic I_PROG_VOLTAGE_SELECT,
  output logic O_SERIAL_PINS_RESERVED,
  output logic O_IN_CIRCUIT_COMM,
  output logic O_LOW_VOLTAGE_DETECTOR_AVAILABLE,
  output logic O_READOUT_PROTECT
);

  localparam logic [16:0] FLASH_BYTES = 17'(FLASH_KB * fspc_pkg::KBYTE);
  localparam logic [15:0] FLASH_BASE = 16'(fspc_pkg::ADDR_SPACE - FLASH_BYTES);
  localparam int NUM_SECTORS = (FLASH_KB <= fspc_pkg::SMALL_KB) ? 1 :
                               (FLASH_KB <= fspc_pkg::MID_KB) ? 2 : 3;

  // Pin synchronisers: stage a feeds stage b only
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic tool_present;
  logic tool_ctrl;
  logic in_application_prog;

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end
    else
    begin
      sync_a <= {I_TOOL_PRESENT, I_PROG_VOLTAGE_SELECT};
      sync_b <= sync_a;
    end
  end

  // Tool owns reset and selects the mode; nothing here overrides it
  assign tool_present = sync_b[1];
  assign tool_ctrl = sync_b[1] & sync_b[0];
  // Without tool control (tool absent or select low), software and its bootloader drive byte program and sector erase outside sector 0
  assign in_application_prog = !tool_ctrl;

  // Bus slave: one wait cycle on every access
  logic ack;
  logic req;
  logic wr_fire;
  logic [7:0] reg_idx;
  logic hit_ctl;
  logic hit_addr;
  logic hit_wdata;
  logic hit_rdata;
  logic hit_opt;

  assign req = I_AVS_READ | I_AVS_WRITE;
  assign O_AVS_WAITREQUEST = req & !ack;
  assign wr_fire = I_AVS_WRITE & ack;
  assign reg_idx = I_AVS_ADDRESS[9:2];
  assign hit_ctl = reg_idx == fspc_pkg::REG_CTL_IDX;
  assign hit_addr = reg_idx == fspc_pkg::REG_ADDR_IDX;
  assign hit_wdata = reg_idx == fspc_pkg::REG_WDATA_IDX;
  assign hit_rdata = reg_idx == fspc_pkg::REG_RDATA_IDX;
  assign hit_opt = reg_idx == fspc_pkg::REG_OPT_IDX;

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= req & !ack;
    end
  end

  // Sector map
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= fspc_pkg::SECTOR0_BASE)
    begin
      sector_of = fspc_pkg::SECT_0;
    end
    else if (NUM_SECTORS > 1 && a >= fspc_pkg::SECTOR1_BASE)
    begin
      sector_of = fspc_pkg::SECT_1;
    end
    else if (NUM_SECTORS > 2 && a >= FLASH_BASE)
    begin
      sector_of = fspc_pkg::SECT_2;
    end
    else
    begin
      sector_of = fspc_pkg::SECT_NONE;
    end
  endfunction : sector_of

  fspc_pkg::fspc_state_e state;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [15:0] cur;
  logic [15:0] last;
  logic rp;
  logic done;
  logic refused;
  logic [1:0] tgt;
  logic ok_target;
  logic busy;
  logic op_end;
  logic cmd_wr;
  logic opt_wr;
  logic any_cmd;
  logic go;
  logic unprot_go;
  logic refuse;
  logic [7:0] wd;

  assign wd = I_AVS_WRITEDATA[7:0];
  assign busy = state != fspc_pkg::S_IDLE;
  assign tgt = sector_of(addr_reg);
  assign ok_target = tgt != fspc_pkg::SECT_NONE &&
                     !(in_application_prog && tgt == fspc_pkg::SECT_0);
  assign cmd_wr = wr_fire & hit_ctl & I_AVS_BYTEENABLE[0];
  assign opt_wr = wr_fire & hit_opt & I_AVS_BYTEENABLE[0];
  assign any_cmd = wd[fspc_pkg::CTL_PROG_BIT] | wd[fspc_pkg::CTL_SERASE_BIT] |
                   wd[fspc_pkg::CTL_MERASE_BIT];
  assign op_end = state == fspc_pkg::S_PROG || (busy && cur == last);

  // Command admission; a refused request never starts the engine
  always_comb
  begin
    go = 1'b0;
    unprot_go = 1'b0;
    refuse = 1'b0;
    if (cmd_wr && any_cmd)
    begin
      if (busy)
      begin
        refuse = 1'b1;
      end
      else if (wd[fspc_pkg::CTL_MERASE_BIT])
      begin
        go = tool_ctrl;
        refuse = !tool_ctrl;
      end
      else
      begin
        go = ok_target;
        refuse = !ok_target;
      end
    end
    else if (opt_wr)
    begin
      if (!tool_ctrl || busy)
      begin
        refuse = 1'b1;
      end
      else
      begin
        unprot_go = rp && !wd[fspc_pkg::OPT_RP_BIT];
      end
    end
  end

  // Erase and program engine
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state <= fspc_pkg::S_IDLE;
      cur <= 16'h0000;
      last <= 16'h0000;
    end
    else
    begin
      unique case (state)
        fspc_pkg::S_IDLE:
        begin
          if (unprot_go)
          begin
            state <= fspc_pkg::S_UNPROT;
            cur <= FLASH_BASE;
            last <= fspc_pkg::ADDR_LAST;
          end
          else if (go && wd[fspc_pkg::CTL_MERASE_BIT])
          begin
            state <= fspc_pkg::S_ERASE;
            cur <= FLASH_BASE;
            last <= fspc_pkg::ADDR_LAST;
          end
          else if (go && wd[fspc_pkg::CTL_SERASE_BIT])
          begin
            state <= fspc_pkg::S_ERASE;
            unique case (tgt)
              fspc_pkg::SECT_0:
              begin
                cur <= fspc_pkg::SECTOR0_BASE;
                last <= fspc_pkg::ADDR_LAST;
              end
              fspc_pkg::SECT_1:
              begin
                cur <= fspc_pkg::SECTOR1_BASE;
                last <= fspc_pkg::SECTOR1_LAST;
              end
              default:
              begin
                cur <= FLASH_BASE;
                last <= fspc_pkg::SECTOR2_LAST;
              end
            endcase
          end
          else if (go)
          begin
            state <= fspc_pkg::S_PROG;
          end
        end
        fspc_pkg::S_PROG:
        begin
          state <= fspc_pkg::S_IDLE;
        end
        fspc_pkg::S_ERASE, fspc_pkg::S_UNPROT:
        begin
          // Sweep stays inside the chosen bounds only
          cur <= 16'(cur + 16'h0001);
          if (cur == last)
          begin
            state <= fspc_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // Software-visible registers
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      addr_reg <= 16'h0000;
      wdata_reg <= fspc_pkg::BYTE_ZERO;
    end
    else if (wr_fire && !busy)
    begin
      // Held steady while the engine runs so targets cannot move
      if (hit_addr && I_AVS_BYTEENABLE[0])
      begin
        addr_reg[7:0] <= wd;
      end
      if (hit_addr && I_AVS_BYTEENABLE[1])
      begin
        addr_reg[15:8] <= I_AVS_WRITEDATA[15:8];
      end
      if (hit_wdata && I_AVS_BYTEENABLE[0])
      begin
        wdata_reg <= wd;
      end
    end
  end

  // Status flags: a hardware set beats a same-cycle software clear
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      done <= fspc_pkg::CTL_RESET[fspc_pkg::CTL_DONE_BIT];
      refused <= fspc_pkg::CTL_RESET[fspc_pkg::CTL_REFUSED_BIT];
    end
    else
    begin
      done <= op_end | (done & !(cmd_wr & wd[fspc_pkg::CTL_DONE_BIT]));
      refused <= refuse | (refused & !(cmd_wr & wd[fspc_pkg::CTL_REFUSED_BIT]));
    end
  end

  // Read-out protection option
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rp <= RP_DEFAULT;
    end
    else if (state == fspc_pkg::S_UNPROT && op_end)
    begin
      rp <= 1'b0;
    end
    else if (opt_wr && tool_ctrl && !busy && wd[fspc_pkg::OPT_RP_BIT])
    begin
      rp <= 1'b1;
    end
  end

  // Flash array
  logic mem_we;
  logic [15:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  assign mem_we = busy;
  assign mem_waddr = (state == fspc_pkg::S_PROG) ? addr_reg : cur;
  assign mem_wdata = (state == fspc_pkg::S_PROG) ? wdata_reg : fspc_pkg::ERASED_BYTE;

  fspc_mem #(
    .AW(16),
    .DW(8)
  ) u_mem (
    .i_clk(I_REF_CLK),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(addr_reg),
    .o_rdata(mem_rdata)
  );

  // Read mux; protected data never reaches the tool
  logic [7:0] rd_mux;
  logic [7:0] ctl_val;

  always_comb
  begin
    ctl_val = fspc_pkg::CTL_RESET;
    ctl_val[fspc_pkg::CTL_BUSY_BIT] = busy;
    ctl_val[fspc_pkg::CTL_DONE_BIT] = done;
    ctl_val[fspc_pkg::CTL_REFUSED_BIT] = refused;
  end

  always_comb
  begin
    rd_mux = fspc_pkg::BYTE_ZERO;
    if (hit_ctl)
    begin
      rd_mux = ctl_val;
    end
    else if (hit_wdata)
    begin
      rd_mux = wdata_reg;
    end
    else if (hit_rdata)
    begin
      rd_mux = (rp && tool_ctrl) ? fspc_pkg::BYTE_ZERO : mem_rdata;
    end
    else if (hit_opt)
    begin
      rd_mux[fspc_pkg::OPT_RP_BIT] = rp;
      rd_mux[fspc_pkg::OPT_DETECTOR_BIT] = !rp;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_AVS_READDATA <= 32'h00000000;
    end
    else if (I_AVS_READ && !ack)
    begin
      O_AVS_READDATA <= hit_addr ? {16'h0000, addr_reg} : {24'h000000, rd_mux};
    end
  end

  assign O_SERIAL_PINS_RESERVED = tool_present;
  assign O_IN_CIRCUIT_COMM = tool_ctrl;
  assign O_LOW_VOLTAGE_DETECTOR_AVAILABLE = !rp;
  assign O_READOUT_PROTECT = rp;

  iap_sector0_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    mem_we && in_application_prog |-> mem_waddr < fspc_pkg::SECTOR0_BASE)
    else $error("sector 0 written in application mode");

  refuse_sec0_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    cmd_wr && any_cmd && in_application_prog && !busy && tgt == fspc_pkg::SECT_0
    |=> refused && state == fspc_pkg::S_IDLE)
    else $error("sector 0 request not refused");

  erase_bound_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    state == fspc_pkg::S_ERASE |-> cur >= FLASH_BASE && cur <= last)
    else $error("erase outside its sector");

  prog_byte_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    go && !wd[fspc_pkg::CTL_MERASE_BIT] && !wd[fspc_pkg::CTL_SERASE_BIT]
    |=> state == fspc_pkg::S_PROG ##1 state == fspc_pkg::S_IDLE && done)
    else $error("byte program not single cycle");

  readout_block_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_AVS_READ && !ack && hit_rdata && rp && tool_ctrl |=> O_AVS_READDATA == 32'h00000000)
    else $error("protected data leaked");

  unprot_erase_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $fell(rp) |-> $past(state) == fspc_pkg::S_UNPROT && $past(cur) == fspc_pkg::ADDR_LAST)
    else $error("protection removed before full erase");

  lvd_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_AVS_READ && !ack && hit_opt && rp |=> !O_AVS_READDATA[fspc_pkg::OPT_DETECTOR_BIT])
    else $error("detector available while protected");

  tool_merase_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    cmd_wr && wd[fspc_pkg::CTL_MERASE_BIT] && tool_ctrl && !busy
    |=> state == fspc_pkg::S_ERASE && cur == FLASH_BASE)
    else $error("tool mass erase not started");

  pins_reserved_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_TOOL_PRESENT [*3] |-> O_SERIAL_PINS_RESERVED)
    else $error("serial pins not reserved");

endmodule : fspc_ctrl

// ### dv/fspc_tool_model.sv
// Programming tool model: attach, in-circuit mode entry, reset line.
// Assumes the bench calls plug from the I_REF_CLK domain.
`timescale 1ns/10ps
module fspc_tool_model (
  input wire logic i_clk,
  output logic o_present,
  output logic o_vsel,
  output logic o_rst_n
);
  initial
  begin
    o_present = 1'b0;
    o_vsel = 1'b0;
    o_rst_n = 1'b1; // Tool owns reset; kept inactive so memory survives
  end
  // Reset, ground, serial pair and select; serial pair not modelled here
  task automatic plug(input logic on, input logic mode_sel);
    @(posedge i_clk);
    o_present <= on;
    o_vsel <= on & mode_sel; // Tool switches device into communication mode
  endtask : plug
endmodule : fspc_tool_model

// ### dv/tb_fspc_ctrl.sv
// Self-checking bench for the flash sector protection controller.
// Assumes a 12K array; bus waits follow waitrequest for up to 50 cycles, then the run fails.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module tb_fspc_ctrl;
  localparam logic [7:0] FC = fspc_pkg::REG_CTL_IDX;
  localparam logic [7:0] AD = fspc_pkg::REG_ADDR_IDX;
  localparam logic [7:0] WD = fspc_pkg::REG_WDATA_IDX;
  localparam logic [7:0] RB = fspc_pkg::REG_RDATA_IDX;
  localparam logic [7:0] OP = fspc_pkg::REG_OPT_IDX;
  logic ref_clk, rst_n, bench_rst_n, tool_rst_n, rd, wr, present, vsel;
  logic waitreq, reserved, comm_mode, detector, prot, chk_now;
  logic [9:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic [7:0] d[4];
  int errors, n_checks, seed;
  assign rst_n = bench_rst_n & tool_rst_n;
  fspc_ctrl #(.FLASH_KB(12), .RP_DEFAULT(1'b0)) i_fspc_ctrl (
    .I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(4'hF), .I_AVS_WRITEDATA(wdata),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_TOOL_PRESENT(present),
    .I_PROG_VOLTAGE_SELECT(vsel), .O_SERIAL_PINS_RESERVED(reserved),
    .O_IN_CIRCUIT_COMM(comm_mode), .O_LOW_VOLTAGE_DETECTOR_AVAILABLE(detector),
    .O_READOUT_PROTECT(prot));
  fspc_tool_model i_fspc_tool_model (.i_clk(ref_clk), .o_present(present),
    .o_vsel(vsel), .o_rst_n(tool_rst_n));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Oldest note is matched against each checked read as it completes
  always @(posedge ref_clk)
  begin
    if (rd && !waitreq && chk_now && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK("readdata", {24'h0, exp_v}, rdata)
    end
  end
  task automatic conclude();
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] v,
      input logic c, output logic [7:0] q);
    int n;
    @(posedge ref_clk);
    chk_now = c;
    if (c && !w)
      exp_q.push_back(v[7:0]);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'h0};
    wdata <= {16'h0, v};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (waitreq && n < 50);
    if (n >= 50)
    begin
      errors++;
      conclude();
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [7:0] idx, input logic [15:0] v);
    logic [7:0] q;
    bus(1'b1, idx, v, 1'b0, q);
  endtask : wreg
  task automatic rreg(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] q;
    bus(1'b0, idx, {8'h0, v}, 1'b1, q);
  endtask : rreg
  // Poll busy; a bound keeps a stuck engine from hanging the run
  task automatic idle();
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h08;
    while (q[fspc_pkg::CTL_BUSY_BIT] !== 1'b0 && n < 20000)
    begin
      bus(1'b0, FC, 16'h0, 1'b0, q);
      n++;
    end
    if (n >= 20000)
    begin
      errors++;
      conclude();
    end
  endtask : idle
  task automatic op(input logic [15:0] a, input logic [7:0] v, input logic [7:0] c,
      input logic [7:0] st);
    wreg(AD, a);
    wreg(WD, {8'h0, v});
    wreg(FC, {8'h0, c});
    idle();
    rreg(FC, st);
    wreg(FC, 16'h0030);
  endtask : op
  task automatic byte_is(input logic [15:0] a, input logic [7:0] v);
    wreg(AD, a);
    rreg(RB, v);
  endtask : byte_is
  task automatic pins(input logic [3:0] e);
    repeat (4) @(posedge ref_clk);
    `CHK("pins", e, {reserved, comm_mode, prot, detector})
  endtask : pins
  initial
  begin
    seed = 32'h9EDB;
    rd = 1'b0;
    wr = 1'b0;
    addr = 10'h0;
    wdata = 32'h0;
    chk_now = 1'b0;
    bench_rst_n = 1'b0;
    errors = 0;
    n_checks = 0;
    for (int k = 0; k < 4; k++)
      d[k] = 8'($random(seed));
    repeat (12) @(posedge ref_clk);
    bench_rst_n <= 1'b1;
    rreg(FC, 8'h00);
    rreg(OP, 8'h02);
    rreg(8'h10, 8'h00);
    pins(4'h1);
    i_fspc_tool_model.plug(1'b1, 1'b1);
    pins(4'hD);
    op(16'hF000, 8'h00, 8'h04, 8'h10);
    op(16'hF000, d[0], 8'h01, 8'h10);
    op(16'hE000, d[1], 8'h01, 8'h10);
    op(16'hD000, d[2], 8'h01, 8'h10);
    op(16'hCFFF, d[3], 8'h01, 8'h20);
    op(16'hFFFF, 8'h00, 8'h02, 8'h10);
    byte_is(16'hF000, 8'hFF);
    byte_is(16'hE000, d[1]);
    byte_is(16'hD000, d[2]);
    // Application mode: tool still plugged, pins stay reserved
    i_fspc_tool_model.plug(1'b1, 1'b0);
    pins(4'h9);
    op(16'hF000, d[3], 8'h01, 8'h20);
    op(16'hF123, 8'h00, 8'h02, 8'h20);
    op(16'hE000, 8'h00, 8'h04, 8'h20);
    byte_is(16'hF000, 8'hFF);
    byte_is(16'hE000, d[1]);
    op(16'hE004, d[3], 8'h01, 8'h10);
    byte_is(16'hE004, d[3]);
    wreg(OP, 16'h0001);
    rreg(FC, 8'h20);
    rreg(OP, 8'h02);
    wreg(FC, 16'h0030);
    // Protection set and removed under tool control
    i_fspc_tool_model.plug(1'b1, 1'b1);
    pins(4'hD);
    wreg(OP, 16'h0001);
    pins(4'hE);
    rreg(OP, 8'h01);
    byte_is(16'hE000, 8'h00);
    wreg(OP, 16'h0000);
    idle();
    pins(4'hD);
    byte_is(16'hE000, 8'hFF);
    byte_is(16'hE004, 8'hFF);
    i_fspc_tool_model.plug(1'b0, 1'b0);
    pins(4'h1);
    conclude();
  end
endmodule : tb_fspc_ctrl
